/* common/sdram_regs.svh */
// register map, field positions, command codes and timing of the sdram core
`ifndef SDRAM_CORE_REGS_SVH
`define SDRAM_CORE_REGS_SVH
// ==========================================================
// apb map
`define CTRL_OFS 12'h000
`define STAT_OFS 12'h004
`define CTRL_RST 32'h0000_0000
`define CTRL_WMASK 32'h0000_001f
// ==========================================================
// ctrl fields
`define CTRL_BL_LSB 0
`define CTRL_BL_MSB 2
`define CTRL_CL3_BIT 3
`define CTRL_BRSW_BIT 4
`define BL_FULL 3'h7
// ==========================================================
// status fields
`define ST_BK0_LSB 0
`define ST_BK0_MSB 1
`define ST_BK1_LSB 2
`define ST_BK1_MSB 3
`define ST_RD_BIT 4
`define ST_WR_BIT 5
`define ST_SUSP_BIT 6
`define ST_PAD_LSB 7
`define ST_PAD_MSB 31
// ==========================================================
// pin commands {cs_n, ras_n, cas_n, we_n}
`define CMD_ACT 4'h3
`define CMD_READ 4'h5
`define CMD_WRITE 4'h4
`define CMD_PRE 4'h2
`define CMD_BST 4'h6
// ==========================================================
// address and storage
`define BANK_BIT 11
`define ALLB_BIT 10
`define COL_MSB 7
`define LANES 2
`define MEM_WORDS 512
// ==========================================================
// timing
`define CLK_NS 4
`define TRP_NS 20
`define TRP_CYC (((`TRP_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define TMR_W 4
`endif

/* common/sdram_pkg.sv */
// state types of the sdram core
package sdram_pkg;
   typedef enum logic [1:0] {BK_IDLE, BK_ACTIVE, BK_PRECHG} bank_state_e;
   typedef enum logic [1:0] {BS_IDLE, BS_READ, BS_WRITE} burst_state_e;
endpackage : sdram_pkg

/* common/rd_pipe_if.sv */
// read word hand-off from the burst engine to the output pipe
`timescale 1ns/1ps
interface rd_pipe_if;
   logic run;
   logic cl3;
   logic valid;
   logic [15:0] data;
   logic [1:0] mask;
   modport src (output run, cl3, valid, data, mask);
   modport sink (input run, cl3, valid, data, mask);
endinterface : rd_pipe_if

/* core/dq_out_pipe.sv */
// cas latency and byte mask output pipe for read data
`timescale 1ns/1ps
module dq_out_pipe (
   input wire logic clk,
   input wire logic nrst,
   rd_pipe_if.sink rp,
   output logic [15:0] dq_out,
   output logic [1:0] dq_oe
);
   logic [1:0] v_r;
   logic [15:0] d0_r;
   logic [15:0] d1_r;
   logic [1:0] mq_r;
   // ==========================================================
   // latency select
   wire sel_v = rp.cl3 ? v_r[1] : v_r[0];
   wire [15:0] sel_d = rp.cl3 ? d1_r : d0_r;
   // ==========================================================
   // pipe, frozen while suspended
   always_ff @(posedge clk) begin
      if (!nrst) begin
         v_r <= 2'h0;
         d0_r <= 16'h0000;
         d1_r <= 16'h0000;
         mq_r <= 2'h0;
         dq_out <= 16'h0000;
         dq_oe <= 2'h0;
      end else if (rp.run) begin
         v_r <= {v_r[0], rp.valid};
         d0_r <= rp.data;
         d1_r <= d0_r;
         mq_r <= rp.mask;
         dq_out <= sel_d;
         dq_oe <= {2{sel_v}} & ~mq_r;
      end
   end
endmodule : dq_out_pipe

/* core/sdram_core.sv */
// sdram bank, burst, byte mask and clock suspend core with apb mode registers
`timescale 1ns/1ps
`include "sdram_regs.svh"
module sdram_core (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic clock_gate_input,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [11:0] addr,
   input wire logic upper_byte_mask,
   input wire logic lower_byte_mask,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output logic [1:0] dq_oe
);
   localparam int TRP_C = `TRP_CYC;
   logic [31:0] ctrl_r;
   logic cke_r;
   sdram_pkg::burst_state_e bs_r;
   sdram_pkg::burst_state_e bs_nxt;
   logic [7:0] cnt_r;
   logic [7:0] start_r;
   logic bank_r;
   logic [15:0] rd_data;

   // ==========================================================
   // suspend: the core runs on edges after clock_gate_input was high
   wire run = cke_r;

   // ==========================================================
   // mode decode
   wire [2:0] bl_code = ctrl_r[`CTRL_BL_MSB:`CTRL_BL_LSB];
   wire cl3 = ctrl_r[`CTRL_CL3_BIT];
   wire brsw = ctrl_r[`CTRL_BRSW_BIT];
   wire full = bl_code == `BL_FULL;
   wire [7:0] blm = full ? 8'hff : ((8'h01 << bl_code[1:0]) - 8'h01);

   // ==========================================================
   // command decode, every command qualified by run; address and mask pins are not
   wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   wire [1:0] dqm = {upper_byte_mask, lower_byte_mask};
   wire bank_sel = addr[`BANK_BIT];
   wire all_bk = addr[`ALLB_BIT];
   wire is_act = run && cmd == `CMD_ACT;
   wire is_rd = run && cmd == `CMD_READ;
   wire is_wr = run && cmd == `CMD_WRITE;
   wire is_pre = run && cmd == `CMD_PRE;
   wire is_bst = run && cmd == `CMD_BST;
   wire is_col = is_rd || is_wr;

   // ==========================================================
   // burst control
   wire busy = bs_r != sdram_pkg::BS_IDLE;
   wire pre_hit = is_pre && (all_bk || bank_sel == bank_r);
   wire stop = busy && (is_bst || pre_hit);
   wire go = run && busy && !stop && !is_col;
   wire rd_word = is_rd || (go && bs_r == sdram_pkg::BS_READ);
   wire wr_mode = is_wr || (go && bs_r == sdram_pkg::BS_WRITE);
   wire word_v = rd_word || wr_mode;
   wire single = wr_mode && brsw;
   wire full_w = full && !single;
   wire [7:0] blm_w = single ? 8'h00 : blm;
   wire [7:0] cnt_w = is_col ? 8'h00 : cnt_r;
   wire [7:0] st_w = is_col ? addr[`COL_MSB:0] : start_r;
   wire bk_w = is_col ? bank_sel : bank_r;
   wire [7:0] col_w = (st_w & ~blm_w) | ((st_w + cnt_w) & blm_w);
   wire last = !full_w && cnt_w == blm_w;
   wire [8:0] idx = {bk_w, col_w};
   wire [1:0] lane_we = {2{wr_mode}} & ~dqm;

   assign bs_nxt = (!word_v || last) ? sdram_pkg::BS_IDLE :
                   (rd_word ? sdram_pkg::BS_READ : sdram_pkg::BS_WRITE);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cke_r <= 1'b1;
      end else begin
         cke_r <= clock_gate_input;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         bs_r <= sdram_pkg::BS_IDLE;
         cnt_r <= 8'h00;
         start_r <= 8'h00;
         bank_r <= 1'b0;
      end else if (run) begin
         bs_r <= bs_nxt;
         cnt_r <= cnt_w + 8'h01;
         start_r <= st_w;
         bank_r <= bk_w;
      end
   end

   // ==========================================================
   // bank state machines; precharge timer runs in real time
   genvar gb;
   generate
      for (gb = 0; gb < 2; gb++) begin : g_bank
         sdram_pkg::bank_state_e st_r;
         logic [`TMR_W-1:0] tmr_r;
         wire me = bank_sel == 1'(gb);
         wire pre_me = is_pre && (all_bk || me);
         always_ff @(posedge clk) begin
            if (!nrst) begin
               st_r <= sdram_pkg::BK_IDLE;
               tmr_r <= '0;
            end else begin
               case (st_r)
                  sdram_pkg::BK_IDLE: begin
                     if (is_act && me) begin
                        st_r <= sdram_pkg::BK_ACTIVE;
                     end
                  end
                  sdram_pkg::BK_ACTIVE: begin
                     if (pre_me) begin
                        st_r <= sdram_pkg::BK_PRECHG;
                        tmr_r <= `TMR_W'(`TRP_CYC - 1);
                     end
                  end
                  sdram_pkg::BK_PRECHG: begin
                     if (tmr_r == '0) begin
                        st_r <= sdram_pkg::BK_IDLE;
                     end else begin
                        tmr_r <= tmr_r - `TMR_W'(1);
                     end
                  end
                  default: begin
                     st_r <= sdram_pkg::BK_IDLE;
                  end
               endcase
            end
         end
      end
   endgenerate

   // ==========================================================
   // storage, one array per byte lane
   genvar gl;
   generate
      for (gl = 0; gl < `LANES; gl++) begin : g_lane
         logic [7:0] mem [`MEM_WORDS];
         always_ff @(posedge clk) begin
            if (lane_we[gl]) begin
               mem[idx] <= dq_in[gl*8 +: 8];
            end
         end
         assign rd_data[gl*8 +: 8] = mem[idx];
      end
   endgenerate

   // ==========================================================
   // read output pipe
   rd_pipe_if rp ();
   assign rp.run = run;
   assign rp.cl3 = cl3;
   assign rp.valid = rd_word;
   assign rp.data = rd_data;
   assign rp.mask = dqm;

   dq_out_pipe u_pipe (
      .clk(clk),
      .nrst(nrst),
      .rp(rp.sink),
      .dq_out(dq_out),
      .dq_oe(dq_oe)
   );

   // ==========================================================
   // apb slave, one wait-free access phase
   wire apb_setup = psel && !penable;
   wire apb_done = psel && penable && pready;
   wire hit_ctrl = paddr == `CTRL_OFS;
   wire hit_stat = paddr == `STAT_OFS;
   wire [31:0] stat_w;
   assign stat_w[`ST_BK0_MSB:`ST_BK0_LSB] = g_bank[0].st_r;
   assign stat_w[`ST_BK1_MSB:`ST_BK1_LSB] = g_bank[1].st_r;
   assign stat_w[`ST_RD_BIT] = bs_r == sdram_pkg::BS_READ;
   assign stat_w[`ST_WR_BIT] = bs_r == sdram_pkg::BS_WRITE;
   assign stat_w[`ST_SUSP_BIT] = !run;
   assign stat_w[`ST_PAD_MSB:`ST_PAD_LSB] = '0;
   wire [31:0] rd_mux = hit_ctrl ? ctrl_r : (hit_stat ? stat_w : 32'h0000_0000);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         ctrl_r <= `CTRL_RST;
      end else begin
         pready <= apb_setup;
         if (apb_setup) begin
            prdata <= rd_mux;
            pslverr <= !(hit_ctrl || hit_stat);
         end
         if (apb_done && pwrite && hit_ctrl) begin
            ctrl_r <= pwdata & `CTRL_WMASK;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_pre_one_bank: assert property (
      is_pre && !all_bk && g_bank[1].st_r == sdram_pkg::BK_ACTIVE && bank_sel
      |=> g_bank[1].st_r == sdram_pkg::BK_PRECHG)
      else $error("selected bank not precharged");

   a_pre_all_bank: assert property (
      is_pre && all_bk |=> g_bank[0].st_r != sdram_pkg::BK_ACTIVE &&
                           g_bank[1].st_r != sdram_pkg::BK_ACTIVE)
      else $error("all bank precharge left a bank active");

   a_trp_idle: assert property (
      is_pre && (all_bk || !bank_sel) && g_bank[0].st_r == sdram_pkg::BK_ACTIVE
      |-> ##(TRP_C) g_bank[0].st_r == sdram_pkg::BK_PRECHG
          ##1 g_bank[0].st_r == sdram_pkg::BK_IDLE)
      else $error("bank idle time wrong");

   a_rd_stop_cl2: assert property (
      (stop && bs_r == sdram_pkg::BS_READ && !cl3 ##1 run [*2]) |-> dq_oe == 2'h0)
      else $error("read not off two cycles after stop");

   a_rd_stop_cl3: assert property (
      (stop && bs_r == sdram_pkg::BS_READ && cl3 ##1 run [*3]) |-> dq_oe == 2'h0)
      else $error("read not off three cycles after stop");

   a_wr_stop_now: assert property (
      stop && bs_r == sdram_pkg::BS_WRITE && !is_col
      |-> lane_we == 2'h0 ##1 bs_r == sdram_pkg::BS_IDLE)
      else $error("write stored past stop");

   a_page_wrap: assert property (
      go && full && cnt_r == 8'hff && !single
      |=> cnt_r == 8'h00 && (!run || col_w == start_r))
      else $error("full page did not wrap to start");

   a_cnt_masked: assert property (
      go && dqm != 2'h0 |=> cnt_r == $past(cnt_r) + 8'h01)
      else $error("masked cycle stalled counter");

   a_rd_pre_tail: assert property (
      stop && bs_r == sdram_pkg::BS_READ && !cl3 && $past(run) && $past(dqm) == 2'h0
      |=> dq_oe == 2'h3)
      else $error("read output cut before last word");

   a_rd_mask: assert property (
      run && lower_byte_mask ##1 run |=> !dq_oe[0])
      else $error("lower lane not off two cycles after mask");

   a_wr_mask: assert property (
      wr_mode && upper_byte_mask |-> !lane_we[1] && lane_we[0] == !lower_byte_mask)
      else $error("write mask lane wrong");

   a_single_wr: assert property (
      is_wr && brsw |=> bs_r == sdram_pkg::BS_IDLE)
      else $error("single write mode kept bursting");

   a_suspend_hold: assert property (
      !clock_gate_input ##1 1'b1 |=> $stable(bs_r) && $stable(cnt_r) && $stable(dq_oe))
      else $error("state moved while suspended");
endmodule : sdram_core

/* verif/sdram_ctl_model.sv */
// controller-side pin driver standing in for the external memory controller
`timescale 1ns/1ps
module sdram_ctl_model (
   input wire logic clk,
   input wire logic [3:0] op,
   input wire logic [11:0] a,
   input wire logic [1:0] m,
   input wire logic dv,
   input wire logic [15:0] d,
   input wire logic cke,
   output logic [3:0] pins,
   output logic [11:0] addr,
   output logic [1:0] masks,
   output logic [15:0] dq_in,
   output logic clock_gate_input
);
   // ==========================================================
   // pins launch just after each edge; a released data bus flips every cycle
   initial begin
      pins = 4'hf;
      addr = 12'h000;
      masks = 2'h0;
      dq_in = 16'h0000;
      clock_gate_input = 1'h1;
   end
   always @(posedge clk) begin
      pins <= op;
      addr <= a;
      masks <= m;
      dq_in <= dv ? d : ~dq_in;
      clock_gate_input <= cke;
   end
endmodule : sdram_ctl_model

/* verif/sdram_bank_precharge_burst_control_tb.sv */
// self-checking bench for the sdram core
`timescale 1ns/1ps
`include "sdram_regs.svh"
module sdram_bank_precharge_burst_control_tb;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
   logic [11:0] paddr = 12'h000, a = 12'h000, addr;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] op = 4'hf, pins;
   logic [1:0] m = 2'h0, masks, dq_oe;
   logic [15:0] d = 16'h0, dq_in, dq_out;
   logic dv = 1'h0, cke = 1'h1, cgi;
   int err_total = 0, compares = 0, cyc = 0;
   sdram_core sdram_core_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clock_gate_input(cgi), .cs_n(pins[3]), .ras_n(pins[2]),
      .cas_n(pins[1]), .we_n(pins[0]), .addr(addr), .upper_byte_mask(masks[1]),
      .lower_byte_mask(masks[0]), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
   sdram_ctl_model sdram_ctl_model_i (.clk(clk), .op(op), .a(a), .m(m), .dv(dv), .d(d),
      .cke(cke), .pins(pins), .addr(addr), .masks(masks), .dq_in(dq_in),
      .clock_gate_input(cgi));
   // ==========================================================
   // clock, timeout and shared tasks
   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         test_done();
      end
   end
   task test_done();
      if (err_total == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   task chk(string name, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task apb(logic w, logic [11:0] ad, logic [31:0] wd);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task step(logic [3:0] o, logic [11:0] ad, logic [1:0] mk, logic v, logic [15:0] dd);
      @(posedge clk);
      op <= o;
      a <= ad;
      m <= mk;
      dv <= v;
      d <= dd;
   endtask : step
   task nop(int n);
      repeat (n) step(4'hf, 12'h000, 2'h0, 1'h0, 16'h0);
   endtask : nop
   task peek(logic [11:0] ad, logic [15:0] e);
      step(`CMD_READ, ad, 2'h0, 1'h0, 16'h0);
      nop(3);
      #1;
      chk("dq_out", 32'(dq_out), 32'(e));
   endtask : peek
   task stat(logic [3:0] e);
      apb(1'h0, `STAT_OFS, 32'h0);
      chk("bank_state", 32'(rd[3:0]), 32'(e));
   endtask : stat
   // ==========================================================
   // scenarios
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'h1;
      apb(1'h0, `CTRL_OFS, 32'h0);
      chk("ctrl", rd, `CTRL_RST);
      apb(1'h1, `CTRL_OFS, 32'hffff_ffff);
      apb(1'h0, `CTRL_OFS, 32'h0);
      chk("ctrl", rd, `CTRL_WMASK);
      apb(1'h0, 12'h010, 32'h0);
      chk("pslverr", 32'(pslverr), 32'h1);
      apb(1'h1, `CTRL_OFS, 32'h1);
      step(`CMD_ACT, 12'h000, 2'h0, 1'h0, 16'h0);
      nop(2);
      step(`CMD_ACT, 12'h800, 2'h0, 1'h0, 16'h0);
      nop(2);
      step(`CMD_WRITE, 12'h008, 2'h0, 1'h1, 16'h1111);
      step(4'hf, 12'h000, 2'h0, 1'h1, 16'h2222);
      step(`CMD_WRITE, 12'h008, 2'h0, 1'h1, 16'h3333);
      step(4'hf, 12'h000, 2'h2, 1'h1, 16'h4444);
      step(`CMD_WRITE, 12'h011, 2'h0, 1'h1, 16'h5555);
      nop(1);
      apb(1'h1, `CTRL_OFS, 32'h11);
      step(`CMD_WRITE, 12'h010, 2'h0, 1'h1, 16'haaaa);
      step(4'hf, 12'h000, 2'h0, 1'h1, 16'hbbbb);
      nop(1);
      apb(1'h1, `CTRL_OFS, 32'h0);
      peek(12'h008, 16'h3333);
      peek(12'h009, 16'h2244);
      peek(12'h010, 16'haaaa);
      peek(12'h011, 16'h5555);
      step(`CMD_WRITE, 12'h023, 2'h0, 1'h1, 16'h0f0f);
      apb(1'h1, `CTRL_OFS, 32'h2);
      step(`CMD_WRITE, 12'h020, 2'h0, 1'h1, 16'h0a0a);
      step(4'hf, 12'h000, 2'h0, 1'h1, 16'h0b0b);
      step(4'hf, 12'h000, 2'h0, 1'h1, 16'h0c0c);
      step(`CMD_PRE, 12'h000, 2'h3, 1'h1, 16'h0d0d);
      step(4'hf, 12'h000, 2'h0, 1'h1, 16'h0e0e);
      stat(4'h6);
      nop(4);
      stat(4'h4);
      step(`CMD_ACT, 12'h000, 2'h0, 1'h0, 16'h0);
      nop(2);
      apb(1'h1, `CTRL_OFS, 32'h0);
      peek(12'h022, 16'h0c0c);
      peek(12'h023, 16'h0f0f);
      apb(1'h1, `CTRL_OFS, 32'ha);
      step(`CMD_READ, 12'h020, 2'h0, 1'h0, 16'h0);
      nop(1);
      step(`CMD_PRE, 12'h000, 2'h0, 1'h0, 16'h0);
      nop(2);
      #1;
      chk("dq_out", 32'(dq_out), 32'h0a0a);
      nop(1);
      #1;
      chk("dq_out", 32'(dq_out), 32'h0b0b);
      nop(1);
      #1;
      chk("dq_oe", 32'(dq_oe), 32'h0);
      nop(6);
      step(`CMD_ACT, 12'h000, 2'h0, 1'h0, 16'h0);
      nop(2);
      step(`CMD_PRE, 12'h800, 2'h0, 1'h0, 16'h0);
      nop(1);
      stat(4'h9);
      nop(6);
      step(`CMD_ACT, 12'h800, 2'h0, 1'h0, 16'h0);
      nop(2);
      step(`CMD_PRE, 12'hc00, 2'h0, 1'h0, 16'h0);
      nop(1);
      stat(4'ha);
      nop(6);
      step(`CMD_ACT, 12'h000, 2'h0, 1'h0, 16'h0);
      apb(1'h1, `CTRL_OFS, 32'h7);
      step(`CMD_WRITE, 12'h040, 2'h0, 1'h1, 16'h0);
      for (int i = 1; i <= 256; i++) step(4'hf, 12'h000, 2'h0, 1'h1, 16'(i));
      step(`CMD_BST, 12'h000, 2'h0, 1'h1, 16'hdead);
      step(`CMD_READ, 12'h040, 2'h0, 1'h0, 16'h0);
      step(4'hf, 12'h000, 2'h1, 1'h0, 16'h0);
      nop(1);
      step(`CMD_BST, 12'h000, 2'h0, 1'h0, 16'h0);
      #1;
      chk("dq_out", 32'(dq_out), 32'h100);
      nop(1);
      #1;
      chk("dq_oe", 32'(dq_oe), 32'h2);
      nop(1);
      #1;
      chk("dq_out", 32'(dq_out), 32'h2);
      chk("dq_oe", 32'(dq_oe), 32'h3);
      nop(1);
      #1;
      chk("dq_oe", 32'(dq_oe), 32'h0);
      step(`CMD_READ, 12'h040, 2'h0, 1'h0, 16'h0);
      nop(2);
      cke <= 1'h0;
      step(`CMD_WRITE, 12'h040, 2'h0, 1'h1, 16'h7777);
      nop(3);
      #1;
      chk("dq_out", 32'(dq_out), 32'h1);
      nop(2);
      cke <= 1'h1;
      nop(3);
      #1;
      chk("dq_out", 32'(dq_out), 32'h2);
      step(`CMD_BST, 12'h000, 2'h0, 1'h0, 16'h0);
      nop(4);
      apb(1'h1, `CTRL_OFS, 32'h0);
      peek(12'h040, 16'h0100);
      peek(12'h041, 16'h0001);
      peek(12'h03f, 16'h00ff);
      step(`CMD_PRE, 12'h000, 2'h0, 1'h0, 16'h0);
      nop(2);
      test_done();
   end
endmodule : sdram_bank_precharge_burst_control_tb
